// ===== core/smc_regs.sv
// Miscellaneous control and status register bank of a three-port switch.
// Assumes link and energy pins are asynchronous; LED, pause and ready
// sources and the register port run on mclk.
`default_nettype none
module smc_regs #(
  parameter int unsigned PAUSE_WAIT = smc_pkg::PAUSE_WAIT_CYC,
  parameter int unsigned SLEEP_UNIT = smc_pkg::SLEEP_UNIT_CYC
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic p1_cu_link,
  input wire logic p1_mii_link,
  input wire logic p2_cu_link,
  input wire logic p3_mii_link,
  input wire logic energy_in,
  input wire logic pause_forced,
  input wire logic led_link,
  input wire logic led_act,
  input wire logic led_speed,
  input wire logic led_duplex,
  input wire logic energy_stretch,
  input wire logic device_ready,
  output logic irq_out_n,
  output logic flow_ctrl_invalidate,
  output logic [5:0] vlan_insert_en,
  output logic cpu_clk_pd_en,
  output logic switch_clk_pd_en,
  output logic pll_off_en,
  output smc_pkg::smc_pm_e pm_mode,
  output logic low_power,
  output logic [1:0] fiber_thresh_high,
  output logic regulator_disable,
  output logic [2:0] invalid_vlan_ports,
  output logic indicator_a,
  output logic indicator_b
);
  import smc_pkg::*;

  typedef struct packed {
    logic [IN_W-1:0] sync1;
    logic [IN_W-1:0] sync2;
    logic [IN_W-1:0] prev;
    logic [7:0] mask;
    logic [7:0] flags;
    logic [7:0] pause_en;
    logic [7:0] fiber;
    logic [7:0] regulator;
    logic [7:0] vlan_ins;
    logic [7:0] pwr_led;
    logic [7:0] sleep;
    logic [7:0] inv_vlan;
    logic [7:0] ed_cnt;
    smc_ed_e ed_state;
    logic [7:0] rdata;
    logic irq_n;
    logic ind_a;
    logic ind_b;
  } smc_state_s;

  smc_state_s st_r;
  smc_state_s st_nxt;
  logic pause_done;
  logic sleep_tick;
  logic pause_run;
  logic sleep_run;

  // ==========================================================
  // Address decode helper
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] off,
                               input logic strobe);
    hit = strobe && (addr == off);
  endfunction : hit

  // ==========================================================
  // Interval timers
  // pause wait timing
  assign pause_run = (st_r.pause_en != 8'h00) && pause_forced;
  assign sleep_run = (smc_pm_e'(st_r.pwr_led[PWR_PM_HI:PWR_PM_LO]) == PM_ENERGY)
                     && !st_r.sync2[IN_ENERGY] && (st_r.ed_state == ED_AWAKE);

  smc_timer #(
    .LIMIT(PAUSE_WAIT)
  ) u_pause_tmr (
    .mclk(mclk),
    .rst_b(rst_b),
    .run(pause_run),
    .done(pause_done)
  );

  smc_timer #(
    .LIMIT(SLEEP_UNIT)
  ) u_sleep_tmr (
    .mclk(mclk),
    .rst_b(rst_b),
    .run(sleep_run),
    .done(sleep_tick)
  );

  // ==========================================================
  // Next-state logic
  always_comb begin
    logic [IN_W-1:0] edge_seen;
    logic [7:0] events;
    logic [7:0] clr;
    smc_led_e led_sel;
    st_nxt = st_r;
    edge_seen = '0;
    events = '0;
    clr = '0;
    led_sel = smc_led_e'(st_r.pwr_led[PWR_LED_SEL_HI:PWR_LED_SEL_LO]);

    // Input synchronisers and change detect
    st_nxt.sync1 = {energy_in, p3_mii_link, p2_cu_link, p1_mii_link, p1_cu_link};
    st_nxt.sync2 = st_r.sync1;
    st_nxt.prev = st_r.sync2;
    edge_seen = st_r.sync2 ^ st_r.prev;

    events[FLAG_P12_CU] = edge_seen[IN_P1_CU] | edge_seen[IN_P2_CU];
    events[FLAG_P3_MII] = edge_seen[IN_P3_MII];
    events[FLAG_P2_CU] = edge_seen[IN_P2_CU];
    events[FLAG_P1_ANY] = edge_seen[IN_P1_CU] | edge_seen[IN_P1_MII];

    // Register writes
    // mask storage
    if (hit(reg_addr, OFF_IRQ_MASK, reg_wr)) begin
      st_nxt.mask = reg_wdata;
    end
    if (hit(reg_addr, OFF_LINK_FLAGS, reg_wr)) begin
      clr = reg_wdata & MASK_FLAGS_W1C;
    end
    st_nxt.flags = (st_r.flags & ~clr) | events;
    if (hit(reg_addr, OFF_PAUSE_LIMIT, reg_wr)) begin
      st_nxt.pause_en = reg_wdata;
    end
    if (hit(reg_addr, OFF_FIBER_LEVEL, reg_wr)) begin
      st_nxt.fiber = reg_wdata & MASK_FIBER;
    end
    if (hit(reg_addr, OFF_REGULATOR, reg_wr)) begin
      st_nxt.regulator = reg_wdata & MASK_REGULATOR;
    end
    if (hit(reg_addr, OFF_VLAN_INSERT, reg_wr)) begin
      st_nxt.vlan_ins = reg_wdata & MASK_VLAN_INSERT;
    end
    if (hit(reg_addr, OFF_POWER_LED, reg_wr)) begin
      st_nxt.pwr_led = reg_wdata;
    end
    if (hit(reg_addr, OFF_SLEEP_DELAY, reg_wr)) begin
      st_nxt.sleep = reg_wdata;
    end
    if (hit(reg_addr, OFF_INVALID_VLAN, reg_wr)) begin
      st_nxt.inv_vlan = reg_wdata & MASK_INVALID_VLAN;
    end

    st_nxt.irq_n = ~|(st_nxt.flags & st_nxt.mask);

    if (smc_pm_e'(st_r.pwr_led[PWR_PM_HI:PWR_PM_LO]) != PM_ENERGY
        || st_r.sync2[IN_ENERGY]) begin
      st_nxt.ed_state = ED_AWAKE;
      st_nxt.ed_cnt = '0;
    end else begin
      case (st_r.ed_state)
        ED_AWAKE: begin
          if (st_r.ed_cnt >= st_r.sleep) begin
            st_nxt.ed_state = ED_ASLEEP;
          end else if (sleep_tick) begin
            st_nxt.ed_cnt = st_r.ed_cnt + 8'h1;
          end
        end
        default: begin
          st_nxt.ed_state = ED_ASLEEP;
        end
      endcase
    end

    if (st_r.pwr_led[PWR_LED_OUT_MODE]) begin
      st_nxt.ind_a = ~device_ready;
      st_nxt.ind_b = ~energy_stretch;
    end else begin
      case (led_sel)
        LED_LA_SPEED: begin
          st_nxt.ind_a = led_link & ~led_act;
          st_nxt.ind_b = led_speed;
        end
        LED_L_ACT: begin
          st_nxt.ind_a = led_link;
          st_nxt.ind_b = led_act;
        end
        LED_LA_DUPLEX: begin
          st_nxt.ind_a = led_link & ~led_act;
          st_nxt.ind_b = led_duplex;
        end
        default: begin
          st_nxt.ind_a = led_link;
          st_nxt.ind_b = led_duplex;
        end
      endcase
    end

    // Read data
    if (!reg_rd) begin
      st_nxt.rdata = st_r.rdata;
    end else if (reg_addr == OFF_IRQ_MASK) begin
      st_nxt.rdata = st_r.mask;
    end else if (reg_addr == OFF_LINK_FLAGS) begin
      st_nxt.rdata = st_r.flags;
    end else if (reg_addr == OFF_PAUSE_LIMIT) begin
      st_nxt.rdata = st_r.pause_en;
    end else if (reg_addr == OFF_FIBER_LEVEL) begin
      st_nxt.rdata = st_r.fiber;
    end else if (reg_addr == OFF_REGULATOR) begin
      st_nxt.rdata = st_r.regulator;
    end else if (reg_addr == OFF_VLAN_INSERT) begin
      st_nxt.rdata = st_r.vlan_ins;
    end else if (reg_addr == OFF_POWER_LED) begin
      st_nxt.rdata = st_r.pwr_led;
    end else if (reg_addr == OFF_SLEEP_DELAY) begin
      st_nxt.rdata = st_r.sleep;
    end else if (reg_addr == OFF_INVALID_VLAN) begin
      st_nxt.rdata = st_r.inv_vlan;
    end else begin
      st_nxt.rdata = 8'h00;
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      st_r.sync1 <= '0;
      st_r.sync2 <= '0;
      st_r.prev <= '0;
      st_r.mask <= RST_IRQ_MASK;
      st_r.flags <= RST_LINK_FLAGS;
      st_r.pause_en <= RST_PAUSE_LIMIT;
      st_r.fiber <= RST_FIBER_LEVEL;
      st_r.regulator <= RST_REGULATOR;
      st_r.vlan_ins <= RST_VLAN_INSERT;
      st_r.pwr_led <= RST_POWER_LED;
      st_r.sleep <= RST_SLEEP_DELAY;
      st_r.inv_vlan <= RST_INVALID_VLAN;
      st_r.ed_cnt <= '0;
      st_r.ed_state <= ED_AWAKE;
      st_r.rdata <= 8'h00;
      st_r.irq_n <= 1'b1;
      st_r.ind_a <= 1'b0;
      st_r.ind_b <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================
  // Outputs
  assign reg_rdata = st_r.rdata;
  assign irq_out_n = st_r.irq_n;
  assign flow_ctrl_invalidate = pause_done;
  assign vlan_insert_en = st_r.vlan_ins[5:0];
  assign cpu_clk_pd_en = st_r.pwr_led[PWR_CPU_PD];
  assign switch_clk_pd_en = st_r.pwr_led[PWR_SW_PD];
  assign pll_off_en = st_r.pwr_led[PWR_PLL_OFF];
  assign pm_mode = smc_pm_e'(st_r.pwr_led[PWR_PM_HI:PWR_PM_LO]);
  assign low_power = (st_r.ed_state == ED_ASLEEP);
  assign fiber_thresh_high = st_r.fiber[7:6];
  assign regulator_disable = st_r.regulator[6];
  assign invalid_vlan_ports = st_r.inv_vlan[6:4];
  assign indicator_a = st_r.ind_a;
  assign indicator_b = st_r.ind_b;
endmodule : smc_regs
`default_nettype wire

// ===== core/smc_timer.sv
// Restartable interval counter giving a pulse every LIMIT cycles of run.
// Assumes run comes from logic on mclk.
`default_nettype none
module smc_timer #(
  parameter int unsigned LIMIT = 1
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic run,
  output logic done
);
  import smc_pkg::*;

  typedef struct packed {
    logic [31:0] cnt;
    logic done;
  } smc_tmr_s;

  localparam logic [31:0] LAST = 32'(LIMIT - 1);

  smc_tmr_s st_r;
  smc_tmr_s st_nxt;

  // ==========================================================
  // Counting
  always_comb begin
    st_nxt = st_r;
    st_nxt.done = 1'b0;
    if (!run) begin
      st_nxt.cnt = '0;
    end else if (st_r.cnt >= LAST) begin
      st_nxt.cnt = '0;
      st_nxt.done = 1'b1;
    end else begin
      st_nxt.cnt = st_r.cnt + 32'h1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign done = st_r.done;
endmodule : smc_timer
`default_nettype wire

// ===== include/smc_pkg.sv
// Constants and types for the switch miscellaneous control register bank.
// Assumes a single 50 MHz clock and the internal byte-wide register port.
`default_nettype none
package smc_pkg;
  // ==========================================================
  // Register offsets
  localparam logic [7:0] OFF_IRQ_MASK = 8'hbb;
  localparam logic [7:0] OFF_LINK_FLAGS = 8'hbc;
  localparam logic [7:0] OFF_PAUSE_LIMIT = 8'hbd;
  localparam logic [7:0] OFF_FIBER_LEVEL = 8'hc0;
  localparam logic [7:0] OFF_REGULATOR = 8'hc1;
  localparam logic [7:0] OFF_VLAN_INSERT = 8'hc2;
  localparam logic [7:0] OFF_POWER_LED = 8'hc3;
  localparam logic [7:0] OFF_SLEEP_DELAY = 8'hc4;
  localparam logic [7:0] OFF_INVALID_VLAN = 8'hc6;
  // ==========================================================
  // Reset values
  localparam logic [7:0] RST_IRQ_MASK = 8'h00;
  localparam logic [7:0] RST_LINK_FLAGS = 8'h00;
  localparam logic [7:0] RST_PAUSE_LIMIT = 8'h00;
  localparam logic [7:0] RST_FIBER_LEVEL = 8'h00;
  localparam logic [7:0] RST_REGULATOR = 8'h00;
  localparam logic [7:0] RST_VLAN_INSERT = 8'h00;
  localparam logic [7:0] RST_POWER_LED = 8'h00;
  localparam logic [7:0] RST_SLEEP_DELAY = 8'h50;
  localparam logic [7:0] RST_INVALID_VLAN = 8'h00;
  // ==========================================================
  // Writable and clearable bit masks
  localparam logic [7:0] MASK_FLAGS_W1C = 8'h87;
  localparam logic [7:0] MASK_FIBER = 8'hc0;
  localparam logic [7:0] MASK_REGULATOR = 8'h40;
  localparam logic [7:0] MASK_VLAN_INSERT = 8'h3f;
  localparam logic [7:0] MASK_INVALID_VLAN = 8'h70;
  // ==========================================================
  // Field positions
  localparam int FLAG_P12_CU = 7;
  localparam int FLAG_P3_MII = 2;
  localparam int FLAG_P2_CU = 1;
  localparam int FLAG_P1_ANY = 0;
  localparam int PWR_CPU_PD = 7;
  localparam int PWR_SW_PD = 6;
  localparam int PWR_LED_SEL_HI = 5;
  localparam int PWR_LED_SEL_LO = 4;
  localparam int PWR_LED_OUT_MODE = 3;
  localparam int PWR_PLL_OFF = 2;
  localparam int PWR_PM_HI = 1;
  localparam int PWR_PM_LO = 0;
  // Synchronised input lanes
  localparam int IN_P1_CU = 0;
  localparam int IN_P1_MII = 1;
  localparam int IN_P2_CU = 2;
  localparam int IN_P3_MII = 3;
  localparam int IN_ENERGY = 4;
  localparam int IN_W = 5;
  // ==========================================================
  // Timing
  localparam longint CLK_HZ = 50000000;
  localparam longint PAUSE_WAIT_MS = 160;
  localparam longint SLEEP_UNIT_MS = 20;
  localparam int unsigned PAUSE_WAIT_CYC = int'((PAUSE_WAIT_MS * CLK_HZ) / 1000);
  localparam int unsigned SLEEP_UNIT_CYC = int'((SLEEP_UNIT_MS * CLK_HZ) / 1000);
  // ==========================================================
  // Modes and states
  typedef enum logic [1:0] {
    PM_NORMAL = 2'h0,
    PM_ENERGY = 2'h1,
    PM_SW_DOWN = 2'h2,
    PM_SAVING = 2'h3
  } smc_pm_e;
  typedef enum logic [1:0] {
    LED_LA_SPEED = 2'h0,
    LED_L_ACT = 2'h1,
    LED_LA_DUPLEX = 2'h2,
    LED_L_DUPLEX = 2'h3
  } smc_led_e;
  typedef enum logic {
    ED_AWAKE = 1'h0,
    ED_ASLEEP = 1'h1
  } smc_ed_e;
endpackage : smc_pkg
`default_nettype wire

// ===== verification/smc_regs_monitor.sv
// Port checks for the misc control register bank.
// Assumes a bind onto smc_regs; sees its ports only.
`default_nettype none
module smc_regs_monitor #(
  parameter int unsigned PAUSE_WAIT = 20
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic pause_forced,
  input wire logic led_link,
  input wire logic led_act,
  input wire logic led_speed,
  input wire logic led_duplex,
  input wire logic energy_stretch,
  input wire logic device_ready,
  input wire logic irq_out_n,
  input wire logic flow_ctrl_invalidate,
  input wire logic [5:0] vlan_insert_en,
  input wire logic cpu_clk_pd_en,
  input wire logic switch_clk_pd_en,
  input wire logic pll_off_en,
  input wire smc_pkg::smc_pm_e pm_mode,
  input wire logic low_power,
  input wire logic indicator_a,
  input wire logic indicator_b
);
  import smc_pkg::*;
  // ==========================================================
  // Helper state
  logic [7:0] led_cfg_r;
  logic [31:0] run_r;
  logic [1:0] led_exp;
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      led_cfg_r <= RST_POWER_LED;
      run_r <= '0;
    end else begin
      if (reg_wr && reg_addr == OFF_POWER_LED) begin
        led_cfg_r <= reg_wdata;
      end
      run_r <= pause_forced ? run_r + 32'h1 : '0;
    end
  end
  always_comb begin
    case (led_cfg_r[5:4])
      2'h0: led_exp = {led_link & ~led_act, led_speed};
      2'h1: led_exp = {led_link, led_act};
      2'h2: led_exp = {led_link & ~led_act, led_duplex};
      default: led_exp = {led_link, led_duplex};
    endcase
    if (led_cfg_r[3]) begin
      led_exp = {~device_ready, ~energy_stretch};
    end
  end
  // ==========================================================
  // Assertions
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  sequence s_wr(logic [7:0] a);
    reg_wr && reg_addr == a;
  endsequence
  chk_reset_outputs:
    assert property (!$past(rst_b) |-> irq_out_n && pm_mode == PM_NORMAL && !low_power
      && vlan_insert_en == 6'h00) else $error("outputs not at reset value");
  chk_vlan_write:
    assert property (s_wr(OFF_VLAN_INSERT) |=> vlan_insert_en == $past(reg_wdata[5:0]))
      else $error("insert enables differ from write");
  chk_power_bits:
    assert property (s_wr(OFF_POWER_LED) |=> {cpu_clk_pd_en, switch_clk_pd_en, pll_off_en,
      pm_mode} == $past({reg_wdata[7:6], reg_wdata[2:0]})) else $error("power bits wrong");
  chk_mask_off:
    assert property (s_wr(OFF_IRQ_MASK) ##0 reg_wdata == 8'h00 |=> irq_out_n)
      else $error("interrupt with mask cleared");
  chk_led_follow:
    assert property ($past(rst_b) |-> {indicator_a, indicator_b} == $past(led_exp))
      else $error("indicator pair wrong");
  chk_lp_leave:
    assert property ($changed(pm_mode) && pm_mode != PM_ENERGY |=> !low_power)
      else $error("sleep kept on mode change");
  chk_lp_rise:
    assert property ($rose(low_power) |-> pm_mode == PM_ENERGY)
      else $error("sleep outside energy mode");
  chk_pause_wait:
    assert property (flow_ctrl_invalidate |-> run_r >= PAUSE_WAIT)
      else $error("invalidate too early");
  chk_pause_pulse:
    assert property (flow_ctrl_invalidate |=> !flow_ctrl_invalidate)
      else $error("invalidate pulse too long");
endmodule : smc_regs_monitor
`default_nettype wire

// ===== verification/smc_regs_tb.sv
// Self-checking bench for the misc control register bank.
// Assumes package, design and monitor are compiled first.
`default_nettype none
module smc_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import smc_pkg::*;
  // ==========================================================
  // Tables and signals
  localparam int unsigned PW = 20;
  localparam logic [7:0] OFFS [9] = '{OFF_IRQ_MASK, OFF_LINK_FLAGS, OFF_PAUSE_LIMIT,
    OFF_FIBER_LEVEL, OFF_REGULATOR, OFF_VLAN_INSERT, OFF_POWER_LED, OFF_SLEEP_DELAY,
    OFF_INVALID_VLAN};
  localparam logic [7:0] RSTV [9] = '{RST_IRQ_MASK, RST_LINK_FLAGS, RST_PAUSE_LIMIT,
    RST_FIBER_LEVEL, RST_REGULATOR, RST_VLAN_INSERT, RST_POWER_LED, RST_SLEEP_DELAY,
    RST_INVALID_VLAN};
  localparam logic [7:0] WMSK [9] = '{8'hff, 8'h00, 8'hff, MASK_FIBER, MASK_REGULATOR,
    MASK_VLAN_INSERT, 8'hff, 8'hff, MASK_INVALID_VLAN};
  localparam logic [7:0] FLG [4] = '{8'h81, 8'h01, 8'h82, 8'h04};
  localparam logic [7:0] LEDX [4] = '{8'h01, 8'h03, 8'h00, 8'h02};
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic [3:0] lnk = 4'h0;
  logic energy_in = 1'b1;
  logic pause_forced = 1'b0;
  logic led_link = 1'b1;
  logic led_act = 1'b1;
  logic led_speed = 1'b1;
  logic led_duplex = 1'b0;
  logic energy_stretch = 1'b0;
  logic device_ready = 1'b0;
  logic irq_out_n, flow_ctrl_invalidate, cpu_clk_pd_en, switch_clk_pd_en, pll_off_en;
  logic low_power, regulator_disable, indicator_a, indicator_b;
  logic [5:0] vlan_insert_en;
  logic [1:0] fiber_thresh_high;
  logic [2:0] invalid_vlan_ports;
  smc_pm_e pm_mode;
  int error_cnt = 0;
  int cmp_count = 0;
  always #10 mclk = ~mclk;
  smc_regs #(.PAUSE_WAIT(PW), .SLEEP_UNIT(10)) dut (
    .mclk, .rst_b, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata,
    .p1_cu_link(lnk[IN_P1_CU]), .p1_mii_link(lnk[IN_P1_MII]), .p2_cu_link(lnk[IN_P2_CU]),
    .p3_mii_link(lnk[IN_P3_MII]), .energy_in, .pause_forced, .led_link, .led_act, .led_speed,
    .led_duplex, .energy_stretch, .device_ready, .irq_out_n, .flow_ctrl_invalidate,
    .vlan_insert_en, .cpu_clk_pd_en, .switch_clk_pd_en, .pll_off_en, .pm_mode, .low_power,
    .fiber_thresh_high, .regulator_disable, .invalid_vlan_ports, .indicator_a, .indicator_b
  );
  // ==========================================================
  // Tasks
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge mclk);
    reg_wr = 1'b0;
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(negedge mclk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge mclk);
    reg_rd = 1'b0;
    check(reg_rdata, exp);
  endtask : rd_chk
  task automatic pulses(output int n);
    n = 0;
    repeat (3 * PW) begin
      @(negedge mclk);
      n += int'(flow_ctrl_invalidate);
    end
  endtask : pulses
  task automatic do_reset;
    @(negedge mclk);
    rst_b = 1'b0;
    repeat (2) @(negedge mclk);
    rst_b = 1'b1;
  endtask : do_reset
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : wrap_up
  // ==========================================================
  // Sequence
  initial begin
    int n;
    do_reset();
    foreach (OFFS[i]) rd_chk(OFFS[i], RSTV[i]);
    rd_chk(8'hbe, 8'h00);
    foreach (OFFS[i]) begin
      wr(OFFS[i], 8'hff);
      rd_chk(OFFS[i], WMSK[i]);
    end
    check({vlan_insert_en, cpu_clk_pd_en, switch_clk_pd_en}, 8'hff);
    check({pll_off_en, pm_mode, fiber_thresh_high, invalid_vlan_ports}, 8'hff);
    check({7'h00, regulator_disable}, 8'h01);
    foreach (OFFS[i]) wr(OFFS[i], 8'h00);
    wr(OFF_IRQ_MASK, 8'hff);
    wr(OFF_LINK_FLAGS, 8'hff);
    for (int i = 0; i < 4; i++) begin
      lnk[i] = ~lnk[i];
      repeat (5) @(negedge mclk);
      rd_chk(OFF_LINK_FLAGS, FLG[i]);
      check({7'h00, irq_out_n}, 8'h00);
      wr(OFF_IRQ_MASK, ~FLG[i]);
      check({7'h00, irq_out_n}, 8'h01);
      wr(OFF_LINK_FLAGS, 8'h00);
      wr(OFF_IRQ_MASK, FLG[i]);
      check({7'h00, irq_out_n}, 8'h00);
      wr(OFF_LINK_FLAGS, FLG[i]);
      rd_chk(OFF_LINK_FLAGS, 8'h00);
      check({7'h00, irq_out_n}, 8'h01);
      wr(OFF_IRQ_MASK, 8'hff);
    end
    lnk = 4'h0;
    repeat (5) @(negedge mclk);
    rd_chk(OFF_LINK_FLAGS, 8'h87);
    wr(OFF_LINK_FLAGS, 8'h87);
    for (int m = 0; m < 4; m++) begin
      wr(OFF_POWER_LED, 8'(m << 4));
      @(negedge mclk);
      check({6'h00, indicator_a, indicator_b}, LEDX[m]);
    end
    energy_stretch = 1'b1;
    wr(OFF_POWER_LED, 8'h08);
    @(negedge mclk);
    check({6'h00, indicator_a, indicator_b}, 8'h02);
    energy_stretch = 1'b0;
    device_ready = 1'b1;
    repeat (2) @(negedge mclk);
    check({6'h00, indicator_a, indicator_b}, 8'h01);
    wr(OFF_PAUSE_LIMIT, 8'h01);
    pause_forced = 1'b1;
    pulses(n);
    check(8'(n), 8'h03);
    wr(OFF_PAUSE_LIMIT, 8'h00);
    pulses(n);
    check(8'(n), 8'h00);
    pause_forced = 1'b0;
    wr(OFF_SLEEP_DELAY, 8'h02);
    energy_in = 1'b0;
    wr(OFF_POWER_LED, 8'h01);
    repeat (10) @(negedge mclk);
    check({7'h00, low_power}, 8'h00);
    repeat (20) @(negedge mclk);
    check({7'h00, low_power}, 8'h01);
    energy_in = 1'b1;
    repeat (5) @(negedge mclk);
    check({7'h00, low_power}, 8'h00);
    wr(OFF_POWER_LED, 8'h00);
    do_reset();
    foreach (OFFS[i]) rd_chk(OFFS[i], RSTV[i]);
    wrap_up();
  end
  initial begin
    repeat (5000) @(posedge mclk);
    error_cnt++;
    wrap_up();
  end
endmodule : smc_regs_tb
bind smc_regs smc_regs_monitor #(.PAUSE_WAIT(PAUSE_WAIT)) mon (
  .mclk, .rst_b, .reg_addr, .reg_wr, .reg_wdata, .pause_forced, .led_link, .led_act,
  .led_speed, .led_duplex, .energy_stretch, .device_ready, .irq_out_n, .flow_ctrl_invalidate,
  .vlan_insert_en, .cpu_clk_pd_en, .switch_clk_pd_en, .pll_off_en, .pm_mode, .low_power,
  .indicator_a, .indicator_b
);
`default_nettype wire
